// ==== shared/flk_pkg.sv ====
// Constants and types shared by the flash lock-and-key guard
package flk_pkg;

	// Special-function address of the key register
	localparam logic [7:0] FLK_KEY_ADDR   = 8'hb7;
	// Key bytes, in the order software must write them
	localparam logic [7:0] FLK_KEY_FIRST  = 8'ha5;
	localparam logic [7:0] FLK_KEY_SECOND = 8'hf1;
	// Reset value of the key register read data
	localparam logic [7:0] FLK_KEY_RESET  = 8'h00;

	// Lock state field position and width in the key register
	localparam int FLK_FIELD_LSB = 0;
	localparam int FLK_FIELD_W   = 2;
	localparam int FLK_DATA_W    = 8;
	localparam int FLK_PAD_W     = FLK_DATA_W - FLK_FIELD_W;

	// Lock state field codes as software reads them
	localparam logic [1:0] FLK_CODE_LOCKED  = 2'h0;
	localparam logic [1:0] FLK_CODE_FIRST   = 2'h1;
	localparam logic [1:0] FLK_CODE_OPEN    = 2'h2;
	localparam logic [1:0] FLK_CODE_LOCKOUT = 2'h3;

	// Guard states
	typedef enum logic [1:0] {
		FLK_LOCKED,
		FLK_FIRST_OK,
		FLK_OPEN,
		FLK_LOCKOUT
	} flk_state_e;

endpackage : flk_pkg

// ==== verilog/flk_sfr_port.sv ====
// Special-function register port of the flash lock-and-key guard
`timescale 1ns/100ps

module flk_sfr_port
	import flk_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	input  wire logic                  ce,
	input  wire logic [7:0]            sfr_addr,
	input  wire logic                  sfr_wr,
	input  wire logic                  sfr_rd,
	input  wire logic [FLK_DATA_W-1:0] sfr_wdata,
	input  wire logic [1:0]            state_code,
	output logic                       key_wr,
	output logic [FLK_DATA_W-1:0]      key_byte,
	output logic [FLK_DATA_W-1:0]      sfr_rdata
);

	logic                  hit;
	logic [FLK_DATA_W-1:0] rdata_q;
	logic [FLK_DATA_W-1:0] rdata_d;

	// Decode ignores the page select, so the key is on every page
	assign hit      = (sfr_addr == FLK_KEY_ADDR); // [R10]
	assign key_wr   = hit && sfr_wr && ce;
	assign key_byte = sfr_wdata;

	// Read data: lock state in the low bits, zeros above
	always_comb
	begin
		rdata_d = FLK_KEY_RESET;
		if (hit && sfr_rd)
		begin
			rdata_d[FLK_FIELD_LSB +: FLK_FIELD_W] = state_code; // [R7]
		end
	end

	// Read data register, zero when the key is not addressed
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdata_q <= FLK_KEY_RESET;
		end
		else if (ce)
		begin
			rdata_q <= rdata_d;
		end
	end

	assign sfr_rdata = rdata_q;

	// Upper bits of a key read are always zero
	a_read_pad_zero : assert property ( // [R7]
		@(posedge clock) disable iff (!rst_b)
		sfr_rdata[FLK_DATA_W-1:FLK_FIELD_W] == '0
	) else $error("Key register upper bits read non-zero");

endmodule : flk_sfr_port

// ==== verilog/flk_key_guard.sv ====
// Flash write and erase lock-and-key guard
//
// How it works
// (R1) Flash writes and erases pass only while the key has unlocked them.
// (R2) Writing 0xa5 then 0xf1 to the key register unlocks flash.
// (R3) One completed write or erase relocks flash automatically.
// (R4) A key write out of sequence locks flash out until reset.
// (R5) A flash attempt while locked is refused and locks flash out.
// (R6) A first key byte other than 0xa5 locks flash out deliberately.
// (R7) Key register reads return the lock state in bits 1 to 0.
// (R8) Field reads 00 when locked, 01 after the first key byte.
// (R9) Field reads 10 when unlocked, 11 during lockout.
// (R10) Key register sits at address 0xb7 on every page.
// (R11) Reset returns the guard to locked, field reading zero.
// (R12) The flash engine pulses attempt and done to the guard.
`timescale 1ns/100ps

module flk_key_guard
	import flk_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	input  wire logic                  ce,
	input  wire logic [7:0]            sfr_addr,
	input  wire logic                  sfr_wr,
	input  wire logic                  sfr_rd,
	input  wire logic [FLK_DATA_W-1:0] sfr_wdata,
	output logic [FLK_DATA_W-1:0]      sfr_rdata,
	input  wire logic                  flash_attempt,
	input  wire logic                  flash_done,
	output logic                       flash_allow,
	output logic                       flash_refused,
	output logic [1:0]                 lock_state,
	output logic                       lockout
);

	flk_state_e            state_q;
	flk_state_e            state_d;
	logic                  key_wr;
	logic [FLK_DATA_W-1:0] key_byte;
	logic                  bad_attempt;
	logic                  allow_q;
	logic                  refused_q;
	logic [1:0]            code_q;
	logic [1:0]            code_d;
	logic                  lockout_q;

	// Register port: decode and registered read data
	flk_sfr_port u_port (
		.clock      (clock),
		.rst_b      (rst_b),
		.ce         (ce),
		.sfr_addr   (sfr_addr),
		.sfr_wr     (sfr_wr),
		.sfr_rd     (sfr_rd),
		.sfr_wdata  (sfr_wdata),
		.state_code (code_q),
		.key_wr     (key_wr),
		.key_byte   (key_byte),
		.sfr_rdata  (sfr_rdata)
	);

	// Engine attempt while not unlocked is a violation
	assign bad_attempt = flash_attempt && (state_q != FLK_OPEN); // [R5] [R12]

	// Next state; lockout causes win over everything else
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			FLK_LOCKED:
			begin
				if (bad_attempt)
				begin
					state_d = FLK_LOCKOUT; // [R5]
				end
				else if (key_wr && key_byte == FLK_KEY_FIRST)
				begin
					state_d = FLK_FIRST_OK; // [R2]
				end
				else if (key_wr)
				begin
					state_d = FLK_LOCKOUT; // [R6]
				end
			end
			FLK_FIRST_OK:
			begin
				if (bad_attempt)
				begin
					state_d = FLK_LOCKOUT; // [R5]
				end
				else if (key_wr && key_byte == FLK_KEY_SECOND)
				begin
					state_d = FLK_OPEN; // [R2]
				end
				else if (key_wr)
				begin
					state_d = FLK_LOCKOUT; // [R4]
				end
			end
			FLK_OPEN:
			begin
				if (key_wr)
				begin
					state_d = FLK_LOCKOUT; // [R4]
				end
				else if (flash_done)
				begin
					state_d = FLK_LOCKED; // [R3] [R12]
				end
			end
			FLK_LOCKOUT:
			begin
				state_d = FLK_LOCKOUT; // [R4]
			end
			default:
			begin
				state_d = FLK_LOCKOUT;
			end
		endcase
	end

	// Guard state; only reset leaves the lockout
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= FLK_LOCKED; // [R11]
		end
		else if (ce)
		begin
			state_q <= state_d;
		end
	end

	// Lock state code of the next state
	always_comb
	begin
		case (state_d)
			FLK_LOCKED:   code_d = FLK_CODE_LOCKED;  // [R8]
			FLK_FIRST_OK: code_d = FLK_CODE_FIRST;   // [R8]
			FLK_OPEN:     code_d = FLK_CODE_OPEN;    // [R9]
			FLK_LOCKOUT:  code_d = FLK_CODE_LOCKOUT; // [R9]
			default:      code_d = FLK_CODE_LOCKOUT;
		endcase
	end

	// Lock state code, tracks the state register
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			code_q <= FLK_CODE_LOCKED; // [R11]
		end
		else if (ce)
		begin
			code_q <= code_d;
		end
	end

	// Permission to the flash engine, only while unlocked
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			allow_q <= 1'b0;
		end
		else if (ce)
		begin
			allow_q <= (state_d == FLK_OPEN); // [R1]
		end
	end

	// Refusal pulse back to the engine
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			refused_q <= 1'b0;
		end
		else if (ce)
		begin
			refused_q <= bad_attempt; // [R5]
		end
	end

	// Lockout flag, sticky until reset
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			lockout_q <= 1'b0;
		end
		else if (ce)
		begin
			lockout_q <= (state_d == FLK_LOCKOUT); // [R4]
		end
	end

	assign flash_allow   = allow_q;
	assign flash_refused = refused_q;
	assign lock_state    = code_q;
	assign lockout       = lockout_q;

	// First key byte written while locked and idle
	sequence s_first_key;
		ce && key_wr && state_q == FLK_LOCKED &&
			key_byte == FLK_KEY_FIRST && !flash_attempt;
	endsequence

	// Second key byte written right after the first
	sequence s_second_key;
		ce && key_wr && key_byte == FLK_KEY_SECOND && !flash_attempt;
	endsequence

	// Idle cycle with no key write and no engine attempt
	sequence s_quiet;
		!key_wr && !flash_attempt;
	endsequence

	a_first_key_ok : assert property ( // [R8]
		@(posedge clock) disable iff (!rst_b)
		s_first_key |=> lock_state == FLK_CODE_FIRST && !flash_allow
	) else $error("First key byte not accepted");

	a_key_pair_open : assert property ( // [R2]
		@(posedge clock) disable iff (!rst_b)
		s_first_key ##1 s_second_key |=>
			flash_allow && lock_state == FLK_CODE_OPEN
	) else $error("Key pair did not unlock flash");

	a_bad_first_key : assert property ( // [R6]
		@(posedge clock) disable iff (!rst_b)
		ce && key_wr && state_q == FLK_LOCKED &&
			key_byte != FLK_KEY_FIRST |=>
			lockout && lock_state == FLK_CODE_LOCKOUT
	) else $error("Wrong first key did not lock out");

	a_bad_second_key : assert property ( // [R4]
		@(posedge clock) disable iff (!rst_b)
		ce && key_wr && state_q == FLK_FIRST_OK &&
			key_byte != FLK_KEY_SECOND |=> lockout && !flash_allow
	) else $error("Wrong second key did not lock out");

	a_refuse_locked : assert property ( // [R5]
		@(posedge clock) disable iff (!rst_b)
		ce && flash_attempt && !flash_allow |=>
			flash_refused && lockout
	) else $error("Locked attempt not refused");

	a_done_relocks : assert property ( // [R3]
		@(posedge clock) disable iff (!rst_b)
		((ce && flash_allow && flash_done) and s_quiet) |=>
			!flash_allow && lock_state == FLK_CODE_LOCKED
	) else $error("Completed operation did not relock");

	a_lockout_sticky : assert property ( // [R4]
		@(posedge clock) disable iff (!rst_b)
		lockout |=> lockout [*4]
	) else $error("Lockout left without reset");

	a_allow_matches : assert property ( // [R1]
		@(posedge clock) disable iff (!rst_b)
		flash_allow == (lock_state == FLK_CODE_OPEN)
	) else $error("Permission disagrees with lock state");

	a_read_state : assert property ( // [R7]
		@(posedge clock) disable iff (!rst_b)
		ce && sfr_rd && sfr_addr == FLK_KEY_ADDR |=>
			sfr_rdata[FLK_FIELD_W-1:0] == $past(lock_state)
	) else $error("Key read returned wrong lock state");

	a_reset_locked : assert property ( // [R11]
		@(posedge clock) disable iff (!rst_b)
		$rose(rst_b) |-> lock_state == FLK_CODE_LOCKED && !lockout
	) else $error("Guard not locked after reset");

	a_frozen_no_ce : assert property (
		@(posedge clock) disable iff (!rst_b)
		!ce |=> $stable(lock_state) && $stable(sfr_rdata)
	) else $error("State moved while clock enable low");

endmodule : flk_key_guard

// ==== testbench/tb.sv ====
// Self-checking testbench for the flash lock-and-key guard
`timescale 1ns/100ps

module tb
	import flk_pkg::*;
;

	logic       clock;
	logic       rst_b;
	logic       ce;
	logic [7:0] sfr_addr;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic       flash_attempt;
	logic       flash_done;
	logic       flash_allow;
	logic       flash_refused;
	logic [1:0] lock_state;
	logic       lockout;
	int         bad_count;
	int         total_checks;
	int         cycles;

	flk_key_guard flk_key_guard_i (
		.clock         (clock),
		.rst_b         (rst_b),
		.ce            (ce),
		.sfr_addr      (sfr_addr),
		.sfr_wr        (sfr_wr),
		.sfr_rd        (sfr_rd),
		.sfr_wdata     (sfr_wdata),
		.sfr_rdata     (sfr_rdata),
		.flash_attempt (flash_attempt),
		.flash_done    (flash_done),
		.flash_allow   (flash_allow),
		.flash_refused (flash_refused),
		.lock_state    (lock_state),
		.lockout       (lockout)
	);

	// Clock of 100 ns period
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Prints the counts and the verdict, then stops
	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	// Hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			wrap_up();
		end
	end

	// Compares one value against its expectation
	task check(input logic [7:0] seen, input logic [7:0] exp,
		input string msg);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : check

	// Compares lockout, flash_allow and lock_state against one lock state code
	task st(input logic [1:0] code);
		check({4'h0, lockout, flash_allow, lock_state},
			{4'h0, code == FLK_CODE_LOCKOUT, code == FLK_CODE_OPEN, code},
			"status");
	endtask : st

	// Holds reset for four cycles
	task do_reset;
		rst_b = 1'b0;
		repeat (4) @(posedge clock);
		#10 rst_b = 1'b1;
	endtask : do_reset

	// One register write
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#10;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clock);
		#10 sfr_wr = 1'b0;
	endtask : wr

	// Two key writes on back-to-back edges, strobe held high between
	task wr2(input logic [7:0] a, input logic [7:0] d1,
		input logic [7:0] d2);
		@(posedge clock);
		#10;
		sfr_addr = a;
		sfr_wdata = d1;
		sfr_wr = 1'b1;
		@(posedge clock);
		#10 sfr_wdata = d2;
		@(posedge clock);
		#10 sfr_wr = 1'b0;
	endtask : wr2

	// One register read, data sampled 10 ns after the taking edge
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		#10;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clock);
		#10 sfr_rd = 1'b0;
		check(sfr_rdata, exp, "read data");
	endtask : rd

	// One engine pulse, refusal sampled the cycle after
	task eng(input logic a, input logic d, input logic ref_exp);
		@(posedge clock);
		#10;
		flash_attempt = a;
		flash_done = d;
		@(posedge clock);
		#10;
		flash_attempt = 1'b0;
		flash_done = 1'b0;
		check({7'h0, flash_refused}, {7'h0, ref_exp}, "refusal");
	endtask : eng

	// Reset state and read value
	task t_reset;
		st(FLK_CODE_LOCKED);
		rd(FLK_KEY_ADDR, FLK_KEY_RESET);
		$display("test reset done");
	endtask : t_reset

	// Unlock, one operation, automatic relock, unlock again
	task t_unlock;
		wr(FLK_KEY_ADDR, FLK_KEY_FIRST);
		st(FLK_CODE_FIRST);
		rd(FLK_KEY_ADDR, 8'h01);
		wr(FLK_KEY_ADDR, FLK_KEY_SECOND);
		st(FLK_CODE_OPEN);
		rd(FLK_KEY_ADDR, 8'h02);
		eng(1'b1, 1'b0, 1'b0);
		st(FLK_CODE_OPEN);
		eng(1'b0, 1'b1, 1'b0);
		st(FLK_CODE_LOCKED);
		eng(1'b0, 1'b1, 1'b0);
		st(FLK_CODE_LOCKED);
		wr2(FLK_KEY_ADDR, FLK_KEY_FIRST, FLK_KEY_SECOND);
		st(FLK_CODE_OPEN);
		wr(FLK_KEY_ADDR, FLK_KEY_FIRST);
		st(FLK_CODE_LOCKOUT);
		do_reset();
		$display("test unlock done");
	endtask : t_unlock

	// Broken key order, sticky lockout, cleared by reset
	task t_bad_seq;
		wr(FLK_KEY_ADDR, FLK_KEY_FIRST);
		wr(FLK_KEY_ADDR, FLK_KEY_FIRST);
		st(FLK_CODE_LOCKOUT);
		wr(FLK_KEY_ADDR, FLK_KEY_FIRST);
		wr(FLK_KEY_ADDR, FLK_KEY_SECOND);
		st(FLK_CODE_LOCKOUT);
		rd(FLK_KEY_ADDR, 8'h03);
		eng(1'b0, 1'b1, 1'b0);
		st(FLK_CODE_LOCKOUT);
		do_reset();
		st(FLK_CODE_LOCKED);
		$display("test sequence done");
	endtask : t_bad_seq

	// Attempts while locked and after first key, refusal a single pulse
	task t_refuse;
		eng(1'b1, 1'b0, 1'b1);
		st(FLK_CODE_LOCKOUT);
		@(posedge clock);
		#10;
		check({7'h0, flash_refused}, 8'h00, "pulse");
		do_reset();
		wr(FLK_KEY_ADDR, FLK_KEY_FIRST);
		eng(1'b1, 1'b0, 1'b1);
		st(FLK_CODE_LOCKOUT);
		do_reset();
		$display("test refuse done");
	endtask : t_refuse

	// Deliberate lock with first bytes other than the key
	task t_deliberate;
		logic [7:0] vals [4];
		vals = '{8'h00, 8'hf1, 8'h5a, 8'hff};
		foreach (vals[i])
		begin
			wr(FLK_KEY_ADDR, vals[i]);
			st(FLK_CODE_LOCKOUT);
			do_reset();
		end
		$display("test deliberate done");
	endtask : t_deliberate

	// Other addresses and a frozen clock enable leave the key alone
	task t_addr;
		wr(8'hb6, FLK_KEY_FIRST);
		wr(8'ha7, 8'h00);
		st(FLK_CODE_LOCKED);
		ce = 1'b0;
		wr(FLK_KEY_ADDR, 8'h33);
		ce = 1'b1;
		st(FLK_CODE_LOCKED);
		wr(FLK_KEY_ADDR, FLK_KEY_FIRST);
		rd(8'hb6, 8'h00);
		wr(FLK_KEY_ADDR, FLK_KEY_SECOND);
		st(FLK_CODE_OPEN);
		$display("test address done");
	endtask : t_addr

	// Main sequence
	initial
	begin
		rst_b = 1'b1;
		ce = 1'b1;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		flash_attempt = 1'b0;
		flash_done = 1'b0;
		bad_count = 0;
		total_checks = 0;
		cycles = 0;
		#10;
		do_reset();
		t_reset();
		t_unlock();
		t_bad_seq();
		t_refuse();
		t_deliberate();
		t_addr();
		wrap_up();
	end

endmodule : tb
